// File: hdl/pic_device.sv
/*
  Eight-level priority interrupt controller: request latching with edge lockout, masks,
  nested, rotating and specific priority, and the three-byte acknowledge answer.
  Assumes the processor end shares i_clk, so link strobes need no synchronisers;
  peripheral request pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
// Operation
// - Rotating mode: serviced level becomes lowest priority.
// - Software may name the lowest level anytime.
// - Masked input never raises an interrupt.
// - Mode and masks change live, apply next.
// - Peripherals request by driving pins high.
// - Accept requests, resolve priority, raise interrupt.
// - Eight priority cells chained in order.
// - Pending register holds requesting levels.
// - In-service register holds levels being served.
// - Mask register, one blocking bit per input.
// - Resolver combines pending, in-service and mask.
// - First acknowledge returns the call opcode.
// - Processor saves counter, issues two more acknowledges.
// - Second pulse low address byte, third high.
// - Processor side produces all three acknowledges.
// - Processor samples interrupt at instruction end, flag set.
// - Interrupt cycle and reset clear accept flag.
// - Processor synchronises the asynchronous interrupt line.
// - Nested default: level 0 highest, 7 lowest.
// - First acknowledge freezes the pending register.
// - After sequence set in-service, clear pending.
// - Edge lockout until acknowledged and released.
module pic_device #(
  parameter logic [15:0] VEC_BASE = pic_pkg::VEC_BASE_RST  // Vector table base address.
) (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Peripheral request pins, asynchronous, active high.
  input  wire logic [7:0] i_req_pins,
  // Processor link.
  pic_if.dev              bus,
  // Observed state.
  output logic      [7:0] o_pending,
  output logic      [7:0] o_in_service,
  output logic      [7:0] o_mask
);
  // Two-stage synchroniser for the request pins.
  logic [7:0]        req_meta_q;
  logic [7:0]        req_sync_q;
  // Edge lockout arming, pending, in-service and mask registers.
  logic [7:0]        armed_q;
  logic [7:0]        pending_request_reg;
  logic [7:0]        active_service_reg;
  logic [7:0]        level_block_reg;
  // Priority control: mode and the level that currently sits at the bottom.
  pic_pkg::pic_mode_t mode_q;
  logic [2:0]        bottom_q;
  // Acknowledge sequence state.
  pic_pkg::pic_ack_t ack_q;
  logic [2:0]        ack_lvl_q;
  logic              ack_prev_q;
  logic              wr_prev_q;
  // Registered interrupt and bus outputs.
  logic              irq_q;
  logic [7:0]        dout_q;
  logic              drive_q;
  // Resolver results.
  logic [7:0]        cand;
  logic [8:0]        req_seen;
  logic [8:0]        srv_seen;
  logic [7:0]        win_pos;
  logic [7:0]        eoi_pos;
  logic [2:0]        pos_lvl [8];
  logic [2:0]        win_lvl;
  logic [2:0]        eoi_lvl;
  logic              win_any;
  logic              eoi_any;
  // Strobe edges and decoded command.
  logic              ack_fall;
  logic              ack_rise;
  logic              wr_take;
  logic              rd_sel;
  logic [2:0]        cmd_op;
  logic              eoi_cmd;
  logic              ack_idle;  // Strobe quiet for two samples and no sequence under way.
  logic              ack_done;  // Third acknowledge pulse has just ended.
  logic [15:0]       vec_addr;

  assign ack_fall = !bus.cpu_irq_ack_strobe_n && ack_prev_q;
  assign ack_idle = ack_q == pic_pkg::ACK_CALL && ack_prev_q && bus.cpu_irq_ack_strobe_n;
  assign ack_done = ack_rise && ack_q == pic_pkg::ACK_HIGH;
  assign ack_rise = bus.cpu_irq_ack_strobe_n && !ack_prev_q;
  assign wr_take  = !bus.cs_n && !bus.wr_n && wr_prev_q;
  assign rd_sel   = !bus.cs_n && !bus.rd_n;
  assign cmd_op   = bus.data[pic_pkg::CMD_OP_MSB:pic_pkg::CMD_OP_LSB];
  assign eoi_cmd  = wr_take && !bus.a0 && (cmd_op == pic_pkg::OP_EOI);

  // Request pins come from outside the clock domain, so two flops before any use.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_meta_q <= 8'h00;
      req_sync_q <= 8'h00;
    end else begin
      req_meta_q <= i_req_pins;
      req_sync_q <= req_meta_q;
    end
  end

  // Strobe history for edge detection; the strobes idle high.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_prev_q <= 1'b1;
      wr_prev_q  <= 1'b1;
    end else begin
      ack_prev_q <= bus.cpu_irq_ack_strobe_n;
      wr_prev_q  <= bus.wr_n || bus.cs_n;
    end
  end

  // A low input re-arms its level; completion of an acknowledge disarms it, so a
  // request still held high cannot fire twice.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      armed_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!req_sync_q[i]) armed_q[i] <= 1'b1;
        else if (ack_done && ack_lvl_q == 3'(i)) armed_q[i] <= 1'b0;
      end
    end
  end

  // Pending bits follow armed, active inputs, but stand still from the first
  // acknowledge to the last so the address bytes match the resolved level.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pending_request_reg <= 8'h00;
    end else if (ack_done) begin
      pending_request_reg            <= req_sync_q & armed_q;
      pending_request_reg[ack_lvl_q] <= 1'b0;
    end else if (ack_idle) begin
      pending_request_reg <= req_sync_q & armed_q;
    end
  end

  // In-service bits are set by a finished sequence and cleared by the done command.
  // A set and a clear of the same level in one cycle leave the bit set.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      active_service_reg <= 8'h00;
    end else begin
      if (eoi_cmd && eoi_any) active_service_reg[eoi_lvl] <= 1'b0;
      if (ack_done) active_service_reg[ack_lvl_q] <= 1'b1;
    end
  end

  // Mask byte is written with a0 high; takes effect on the next resolution.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      level_block_reg <= pic_pkg::MASK_RST;
    end else if (wr_take && bus.a0) begin
      level_block_reg <= bus.data;
    end
  end

  // Mode and bottom level. Nested mode pins level 7 at the bottom; rotation moves
  // the level just finished to the bottom when its service is declared done.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q   <= pic_pkg::MODE_NESTED;
      bottom_q <= pic_pkg::BOTTOM_RST;
    end else if (wr_take && !bus.a0) begin
      unique case (cmd_op)
        pic_pkg::OP_NESTED: begin
          mode_q   <= pic_pkg::MODE_NESTED;
          bottom_q <= pic_pkg::BOTTOM_RST;
        end
        pic_pkg::OP_ROTATE: mode_q <= pic_pkg::MODE_ROTATE;
        pic_pkg::OP_SPECIFIC: begin
          mode_q   <= pic_pkg::MODE_SPECIFIC;
          bottom_q <= bus.data[pic_pkg::CMD_LVL_MSB:pic_pkg::CMD_LVL_LSB];
        end
        pic_pkg::OP_EOI: begin
          if (mode_q != pic_pkg::MODE_NESTED && eoi_any) bottom_q <= eoi_lvl;
        end
        default: bottom_q <= bottom_q;
      endcase
    end
  end
  // Masked requests never reach the cells.
  assign cand = pending_request_reg & ~level_block_reg;

  // One cell per level, chained from highest to lowest priority. A request wins
  // only if no higher request and no equal or higher service stands before it.
  assign req_seen[0] = 1'b0;
  assign srv_seen[0] = 1'b0;
  for (genvar k = 0; k < 8; k++) begin : g_cell
    assign pos_lvl[k]    = 3'(bottom_q + 3'(k) + 3'h1);
    assign req_seen[k+1] = req_seen[k] | cand[pos_lvl[k]];
    assign srv_seen[k+1] = srv_seen[k] | active_service_reg[pos_lvl[k]];
    assign win_pos[k]    = cand[pos_lvl[k]] & ~req_seen[k] & ~srv_seen[k+1];
    assign eoi_pos[k]    = active_service_reg[pos_lvl[k]] & ~srv_seen[k];
  end

  // Encode the winning and the top in-service positions back into levels.
  always_comb begin
    win_lvl = 3'h0;
    eoi_lvl = 3'h0;
    for (int k = 0; k < 8; k++) begin
      if (win_pos[k]) win_lvl = pos_lvl[k];
      if (eoi_pos[k]) eoi_lvl = pos_lvl[k];
    end
  end
  assign win_any = |win_pos;
  assign eoi_any = |eoi_pos;

  // Interrupt line is high while a winner stands and no sequence is under way.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= win_any && ack_idle;
    end
  end

  // Sequence steps on each rising acknowledge edge; level caught on the first fall.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q     <= pic_pkg::ACK_CALL;
      ack_lvl_q <= 3'h0;
    end else begin
      if (ack_fall && ack_q == pic_pkg::ACK_CALL) ack_lvl_q <= win_lvl;
      if (ack_rise) begin
        unique case (ack_q)
          pic_pkg::ACK_CALL: ack_q <= pic_pkg::ACK_LOW;
          pic_pkg::ACK_LOW:  ack_q <= pic_pkg::ACK_HIGH;
          pic_pkg::ACK_HIGH: ack_q <= pic_pkg::ACK_CALL;
        endcase
      end
    end
  end
  // Vector for the level that was caught; spacing four bytes.
  assign vec_addr = 16'(VEC_BASE + {11'h000, ack_lvl_q, 2'b00});

  // Bus drive is registered, so it starts one cycle after the strobe falls and
  // ends one cycle after it rises; the processor samples late in its pulse.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drive_q <= 1'b0;
      dout_q  <= 8'h00;
    end else begin
      drive_q <= !bus.cpu_irq_ack_strobe_n || rd_sel;
      if (!bus.cpu_irq_ack_strobe_n) begin
        unique case (ack_q)
          pic_pkg::ACK_CALL: dout_q <= pic_pkg::CALL_OPCODE;
          pic_pkg::ACK_LOW:  dout_q <= vec_addr[7:0];
          pic_pkg::ACK_HIGH: dout_q <= vec_addr[15:8];
        endcase
      end else if (rd_sel) begin
        dout_q <= bus.a0 ? active_service_reg : pending_request_reg;
      end
    end
  end

  assign bus.irq      = irq_q;
  assign bus.dev_dout = dout_q;
  assign bus.dev_oe_n = !drive_q;
  assign o_pending    = pending_request_reg;
  assign o_in_service = active_service_reg;
  assign o_mask       = level_block_reg;
endmodule : pic_device

// File: include/pic_pkg.sv
/*
  Shared constants and types for the priority interrupt controller and its processor end.
  Assumes one 50 MHz clock shared by both ends and an 8-bit multiplexed data bus.
*/
package pic_pkg;
  // Number of request levels and data bus width.
  localparam int NUM_LEVELS = 8;
  localparam int DATA_W     = 8;

  // Opcode returned on the first acknowledge pulse (three-byte call).
  localparam logic [7:0] CALL_OPCODE = 8'hcd;

  // Service routine vectors are spaced four bytes apart above a base.
  localparam logic [15:0] VEC_BASE_RST = 16'h0000;
  localparam int          VEC_SHIFT    = 2;

  // Reset values of the control state.
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [2:0] BOTTOM_RST = 3'h7;

  // Command byte layout (written with a0 low); a0 high writes the mask byte.
  localparam int CMD_OP_MSB  = 7;
  localparam int CMD_OP_LSB  = 5;
  localparam int CMD_LVL_MSB = 2;
  localparam int CMD_LVL_LSB = 0;
  localparam logic [2:0] OP_EOI      = 3'h1;
  localparam logic [2:0] OP_NESTED   = 3'h2;
  localparam logic [2:0] OP_ROTATE   = 3'h3;
  localparam logic [2:0] OP_SPECIFIC = 3'h4;

  // Timing of the processor end's strobes.
  localparam int CLK_PERIOD_NS = 20;
  localparam int PULSE_NS      = 60;
  localparam int GAP_NS        = 40;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Priority ordering modes.
  typedef enum logic [1:0] {MODE_NESTED, MODE_ROTATE, MODE_SPECIFIC} pic_mode_t;

  // Position inside the three-pulse acknowledge sequence.
  typedef enum logic [1:0] {ACK_CALL, ACK_LOW, ACK_HIGH} pic_ack_t;
endpackage : pic_pkg

// File: include/pic_if.sv
/*
  Link between the controller and the processor end: interrupt line, acknowledge strobe,
  command/status strobes and the shared data bus. Assumes both ends run on one clock.
*/
`timescale 1ns/1ps
interface pic_if;
  // Interrupt line toward the processor, active high.
  logic       irq;
  // Acknowledge strobe, active low.
  logic       cpu_irq_ack_strobe_n;
  // Command and status strobes, all active low, plus register select.
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       a0;
  // Data bus halves; each output enable is low while that end drives.
  logic [7:0] dev_dout;
  logic       dev_oe_n;
  logic [7:0] cpu_dout;
  logic       cpu_oe_n;
  logic [7:0] data;

  // Resolved bus level; an undriven bus floats high through a pull-up.
  assign data = !dev_oe_n ? dev_dout : (!cpu_oe_n ? cpu_dout : 8'hff);

  modport dev (output irq, dev_dout, dev_oe_n,
               input cpu_irq_ack_strobe_n, cs_n, wr_n, rd_n, a0, data);
  modport cpu (input irq, data,
               output cpu_irq_ack_strobe_n, cs_n, wr_n, rd_n, a0, cpu_dout, cpu_oe_n);
endinterface : pic_if

// File: hdl/pic_cpu.sv
/*
  Processor end of the link: interrupt acceptance flag, three-pulse acknowledge
  sequence that fetches the call and its address, and command/status bus cycles.
  Assumes the controller shares i_clk; the interrupt line is still synchronised.
*/
`timescale 1ns/1ps
module pic_cpu (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Instruction boundary and acceptance flag control.
  input  wire logic        i_instr_end,
  input  wire logic        i_accept_set,
  input  wire logic        i_accept_clr,
  output logic             o_accept_flag,
  // Command and status requests.
  input  wire logic        i_wr_req,
  input  wire logic        i_rd_req,
  input  wire logic        i_a0,
  input  wire logic  [7:0] i_wdata,
  output logic             o_busy,
  output logic       [7:0] o_rdata,
  output logic             o_rdata_valid,
  // Fetched interrupt call.
  output logic      [15:0] o_vector,
  output logic             o_vector_valid,
  output logic             o_call_ok,
  // Controller link.
  pic_if.cpu               bus
);
  // Bus cycle states.
  typedef enum {S_IDLE, S_WR, S_RD, S_ACK, S_GAP} pic_cpu_st_t;
  pic_cpu_st_t st_q;
  logic [3:0]  cnt_q;          // Cycles left in the current phase.
  logic [1:0]  byte_q;         // Acknowledge pulse index, 0 to 2.
  logic        irq_meta_q;     // Synchroniser first stage.
  logic        irq_sync_q;     // Synchroniser second stage.
  logic        cpu_irq_accept_flag;
  logic        a0_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [15:0] vec_q;
  logic        vvalid_q;
  logic        call_ok_q;
  logic        take_irq;

  // The interrupt line may change at any moment relative to this end.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= bus.irq;
      irq_sync_q <= irq_meta_q;
    end
  end

  // Interrupts are taken only at an instruction end with the flag set.
  assign take_irq = st_q == S_IDLE && i_instr_end && irq_sync_q && cpu_irq_accept_flag;

  // Accept flag: cleared by reset and by entering an interrupt cycle.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cpu_irq_accept_flag <= 1'b0;
    end else if (take_irq || i_accept_clr) begin
      cpu_irq_accept_flag <= 1'b0;
    end else if (i_accept_set) begin
      cpu_irq_accept_flag <= 1'b1;
    end
  end

  // One sequencer for commands, status reads and the acknowledge burst; the
  // burst always runs to three pulses so the controller never stalls mid-call.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q      <= S_IDLE;
      cnt_q     <= 4'h0;
      byte_q    <= 2'h0;
      a0_q      <= 1'b0;
      wdata_q   <= 8'h00;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
      vec_q     <= 16'h0000;
      vvalid_q  <= 1'b0;
      call_ok_q <= 1'b0;
    end else begin
      rvalid_q <= 1'b0;
      vvalid_q <= 1'b0;
      unique case (st_q)
        S_IDLE: begin
          cnt_q  <= 4'(pic_pkg::PULSE_CYC - 1);
          byte_q <= 2'h0;
          if (take_irq) begin
            st_q <= S_ACK;
          end else if (i_wr_req) begin
            st_q    <= S_WR;
            a0_q    <= i_a0;
            wdata_q <= i_wdata;
          end else if (i_rd_req) begin
            st_q <= S_RD;
            a0_q <= i_a0;
          end
        end
        S_WR, S_RD: begin
          if (cnt_q == 4'h0) begin
            st_q     <= S_IDLE;
            rdata_q  <= (st_q == S_RD) ? bus.data : rdata_q;
            rvalid_q <= st_q == S_RD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_ACK: begin
          if (cnt_q == 4'h0) begin
            unique case (byte_q)
              2'h0: call_ok_q <= bus.data == pic_pkg::CALL_OPCODE;
              2'h1: vec_q[7:0] <= bus.data;
              default: vec_q[15:8] <= bus.data;
            endcase
            st_q  <= S_GAP;
            cnt_q <= 4'(pic_pkg::GAP_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_GAP: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (byte_q == 2'h2) begin
            st_q     <= S_IDLE;
            vvalid_q <= 1'b1;
          end else begin
            byte_q <= byte_q + 2'h1;
            st_q   <= S_ACK;
            cnt_q  <= 4'(pic_pkg::PULSE_CYC - 1);
          end
        end
      endcase
    end
  end

  // Strobes decoded from the state; only writes drive the data bus.
  assign bus.cpu_irq_ack_strobe_n = st_q != S_ACK;
  assign bus.cs_n     = !(st_q == S_WR || st_q == S_RD);
  assign bus.wr_n     = st_q != S_WR;
  assign bus.rd_n     = st_q != S_RD;
  assign bus.a0       = a0_q;
  assign bus.cpu_dout = wdata_q;
  assign bus.cpu_oe_n = st_q != S_WR;
  assign o_accept_flag  = cpu_irq_accept_flag;
  assign o_busy         = st_q != S_IDLE;
  assign o_rdata        = rdata_q;
  assign o_rdata_valid  = rvalid_q;
  assign o_vector       = vec_q;
  assign o_vector_valid = vvalid_q;
  assign o_call_ok      = call_ok_q;
endmodule : pic_cpu

// File: test/pic_properties.sv
/* Assertions on the link between controller and processor end.
   Assumes the link signals, shared clock and reset arrive as inputs. */
`timescale 1ns/1ps
module pic_properties (
  // Clock and reset.
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Link signals.
  input wire logic       irq,
  input wire logic       cpu_irq_ack_strobe_n,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       dev_oe_n,
  input wire logic [7:0] dev_dout
);
  logic       ack_q;    // Strobe level one cycle ago.
  logic [1:0] pulse_q;  // Pulses finished in this sequence.
  logic       mid;      // Strobe low for a second cycle or more.

  // Count pulses modulo three, so each byte is tied to its place.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q   <= 1'h1;
      pulse_q <= 2'h0;
    end else begin
      ack_q <= cpu_irq_ack_strobe_n;
      if (cpu_irq_ack_strobe_n && !ack_q) begin
        pulse_q <= (pulse_q == 2'h2) ? 2'h0 : pulse_q + 2'h1;
      end
    end
  end
  assign mid = !cpu_irq_ack_strobe_n && !ack_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_call_opcode: assert property (mid && pulse_q == 2'h0 |->
    !dev_oe_n && dev_dout == pic_pkg::CALL_OPCODE) else $error("call opcode wrong");
  a_low_byte: assert property (mid && pulse_q == 2'h1 |->
    !dev_oe_n && dev_dout[1:0] == 2'h0 && dev_dout[7:5] == 3'h0) else $error("low byte wrong");
  a_high_byte: assert property (mid && pulse_q == 2'h2 |->
    !dev_oe_n && dev_dout == 8'h00) else $error("high byte wrong");
  a_pulse_width: assert property ($fell(cpu_irq_ack_strobe_n) |->
    !cpu_irq_ack_strobe_n [*3] ##1 cpu_irq_ack_strobe_n) else $error("pulse width wrong");
  a_next_pulse: assert property ($rose(cpu_irq_ack_strobe_n) && pulse_q != 2'h2 |->
    ##[1:4] $fell(cpu_irq_ack_strobe_n)) else $error("acknowledge pulse missing");
  a_irq_drops: assert property ($fell(cpu_irq_ack_strobe_n) && pulse_q == 2'h0 |=>
    !irq [*8]) else $error("interrupt raised during acknowledge");
  a_bus_release: assert property (!dev_oe_n |-> !cpu_irq_ack_strobe_n || !rd_n ||
    !$past(cpu_irq_ack_strobe_n) || !$past(rd_n)) else $error("bus driven while idle");
  a_read_drive: assert property ($fell(rd_n) && !cs_n |=> !dev_oe_n)
    else $error("status read not driven");
endmodule : pic_properties

// File: test/tb_top.sv
/* Bench joining controller and processor end through the link.
   Assumes a 50 MHz clock; the processor end sees every cycle as an instruction end except during the check that holds instr_end low. */
`timescale 1ns/1ps
module tb_top;
  logic        i_clk, i_rst;     // Clock and reset.
  logic [7:0]  pins;             // Peripheral request pins.
  logic        acc_set, acc_clr; // Acceptance flag control.
  logic        instr_end;        // Instruction boundary seen by the processor end.
  logic        wr_req, rd_req, a0, acc_flag, busy, rvalid, vvalid, call_ok;
  logic [7:0]  wdata, rdata, pend, insvc, mask;
  logic [15:0] vector;
  int          miscompares, compares;

  pic_if link ();
  pic_device u_pic_device (.i_clk(i_clk), .i_rst(i_rst), .i_req_pins(pins), .bus(link),
    .o_pending(pend), .o_in_service(insvc), .o_mask(mask));
  pic_cpu u_pic_cpu (.i_clk(i_clk), .i_rst(i_rst), .i_instr_end(instr_end),
    .i_accept_set(acc_set), .i_accept_clr(acc_clr), .o_accept_flag(acc_flag),
    .i_wr_req(wr_req), .i_rd_req(rd_req), .i_a0(a0), .i_wdata(wdata), .o_busy(busy),
    .o_rdata(rdata), .o_rdata_valid(rvalid), .o_vector(vector), .o_vector_valid(vvalid),
    .o_call_ok(call_ok), .bus(link));
  pic_properties u_props (.i_clk(i_clk), .i_rst(i_rst), .irq(link.irq),
    .cpu_irq_ack_strobe_n(link.cpu_irq_ack_strobe_n), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .dev_oe_n(link.dev_oe_n), .dev_dout(link.dev_dout));

  // Free-running clock.
  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // Inputs change one nanosecond after the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // A wait that ran out ends the run as a failure.
  task automatic hang();
    miscompares++;
    complete_run();
  endtask : hang

  // One command write or status read, waiting until the processor end is free.
  task automatic bus_op(input logic wr, input logic sel, input logic [7:0] d);
    int n;
    a0 = sel;
    wdata = d;
    wr_req = wr;
    rd_req = !wr;
    tick(1);
    wr_req = 1'h0;
    rd_req = 1'h0;
    for (n = 0; n < 20 && !(wr ? busy === 1'h0 : rvalid === 1'h1); n++) tick(1);
    for (; n < 20 && busy !== 1'h0; n++) tick(1);
    if (n == 20) hang();
  endtask : bus_op

  // Enable interrupts and take one call; its vector names the level.
  task automatic serve(input int lvl);
    int n;
    acc_set = 1'h1;
    tick(1);
    acc_set = 1'h0;
    for (n = 0; n < 60 && vvalid !== 1'h1; n++) tick(1);
    if (n == 60) hang();
    check("vector", vector, 16'(lvl * 4));
    check("call_ok", {15'h0, call_ok}, 16'h0001);
    check("accept", {15'h0, acc_flag}, 16'h0000);
  endtask : serve

  initial begin
    i_rst = 1'h1;
    pins = 8'h00;
    {acc_set, acc_clr, wr_req, rd_req, a0} = 5'h00;
    instr_end = 1'h1;
    wdata = 8'h00;
    miscompares = 0;
    compares = 0;
    tick(12);
    i_rst = 1'h0;
    tick(2);
    check("mask", {8'h00, mask}, 16'h0000);
    check("pending", {8'h00, pend}, 16'h0000);
    check("accept", {15'h0, acc_flag}, 16'h0000);
    acc_set = 1'h1;
    tick(1);
    acc_set = 1'h0;
    acc_clr = 1'h1;
    tick(1);
    acc_clr = 1'h0;
    check("accept", {15'h0, acc_flag}, 16'h0000);
    // Two levels at once in nested order; level 3 wins over 5.
    pins = 8'h28;
    tick(5);
    check("pending", {8'h00, pend}, 16'h0028);
    check("irq", {15'h0, link.irq}, 16'h0001);
    // With the flag set but no instruction end, the call must not start.
    instr_end = 1'h0;
    acc_set = 1'h1;
    tick(1);
    acc_set = 1'h0;
    check("accept", {15'h0, acc_flag}, 16'h0001);
    tick(4);
    check("busy", {15'h0, busy}, 16'h0000);
    instr_end = 1'h1;
    serve(3);
    check("in_service", {8'h00, insvc}, 16'h0008);
    check("pending", {8'h00, pend}, 16'h0020);
    tick(4);
    check("irq", {15'h0, link.irq}, 16'h0000);
    // A higher level preempts the running service.
    pins = 8'h2a;
    tick(5);
    serve(1);
    check("in_service", {8'h00, insvc}, 16'h000a);
    bus_op(1'h1, 1'h0, 8'h20);
    bus_op(1'h1, 1'h0, 8'h20);
    check("pending", {8'h00, pend}, 16'h0020);
    serve(5);
    bus_op(1'h0, 1'h1, 8'h00);
    check("read", {8'h00, rdata}, 16'h0020);
    bus_op(1'h1, 1'h0, 8'h20);
    // Masked level pends but stays silent until unmasked.
    pins = 8'h00;
    tick(4);
    bus_op(1'h1, 1'h1, 8'h08);
    check("mask", {8'h00, mask}, 16'h0008);
    pins = 8'h08;
    tick(8);
    check("irq", {15'h0, link.irq}, 16'h0000);
    bus_op(1'h0, 1'h0, 8'h00);
    check("read", {8'h00, rdata}, 16'h0008);
    bus_op(1'h1, 1'h1, 8'h00);
    tick(3);
    check("irq", {15'h0, link.irq}, 16'h0001);
    serve(3);
    bus_op(1'h1, 1'h0, 8'h20);
    // Rotating: a served level drops to the bottom.
    pins = 8'h00;
    tick(4);
    bus_op(1'h1, 1'h0, 8'h60);
    pins = 8'h04;
    tick(5);
    serve(2);
    bus_op(1'h1, 1'h0, 8'h20);
    pins = 8'h00;
    tick(4);
    pins = 8'h42;
    tick(5);
    serve(6);
    bus_op(1'h1, 1'h0, 8'h20);
    serve(1);
    bus_op(1'h1, 1'h0, 8'h20);
    // Specific: software names level 0 as the bottom.
    pins = 8'h00;
    tick(4);
    bus_op(1'h1, 1'h0, 8'h80);
    pins = 8'h03;
    tick(5);
    serve(1);
    bus_op(1'h1, 1'h0, 8'h20);
    serve(0);
    bus_op(1'h1, 1'h0, 8'h20);
    bus_op(1'h1, 1'h0, 8'h40);
    check("in_service", {8'h00, insvc}, 16'h0000);
    complete_run();
  end
endmodule : tb_top
